// ---- hw/usa_pkg.sv ----
// Purpose: shared constants and types for the serial transceiver core
// Assumes: one peripheral clock, configuration held static during frames
// Notes: frame vectors are sent bit 0 first
package usa_pkg;
    localparam int BAUD_W = 12;            // Width of the baud period setting
    localparam int FRAME_W = 13;           // Start, nine data, parity, two stops
    localparam logic [3:0] OS_LAST = 4'hf; // Last oversample tick of an async bit
    localparam logic [3:0] OS_MID = 4'h7;  // Async sample point inside a bit
    localparam logic [3:0] DBITS_SPI = 4'h8; // SPI character length
    localparam logic [3:0] FIFO_FULL = 4'h2; // Receive buffer entries
    localparam logic [BAUD_W-1:0] BAUD_RST = '0;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0,
        MODE_SYNC_MASTER = 2'h1,
        MODE_SYNC_SLAVE = 2'h2,
        MODE_SPI = 2'h3
    } usa_mode_t;

    // Parity selection
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_RSVD = 2'h1,
        PAR_EVEN = 2'h2,
        PAR_ODD = 2'h3
    } usa_par_t;

    // Static configuration bundle
    typedef struct packed {
        usa_mode_t mode;
        logic [3:0] data_bits;  // 5 to 9
        usa_par_t parity;
        logic two_stop;
        logic pin_invert;
        logic spi_clock_phase;
        logic spi_lsb_first;
    } usa_cfg_t;

    // One receive buffer entry with its own status
    typedef struct packed {
        logic overrun_flag;
        logic frame_error_flag;
        logic parity_error_flag;
        logic rx_ninth_bit;
        logic [7:0] data;
    } usa_rx_entry_t;

    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} usa_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RECV = 2'b10} usa_rx_state_t;
endpackage

// ---- hw/usa_core.sv ----
// Purpose: serial transceiver, async, sync master/slave and SPI master
// Assumes: cfg_i changes only while both directions are idle
// Notes: one baud divider paces every mode except sync slave, which is clocked from the pin
// Summary of operation
// - sync sampling on edge opposite to change
// - no inversion: change rising, sample falling
// - SPI clock comes from internal divider only
// - phase and inversion pick four SPI modes
// - frame: start, 5-9 data, parity, stops
// - start, data lsb first, parity, stops, idle high
// - even parity one when ones count odd
// - SPI frame eight bits, selectable order
// - buffer loads shifter when idle or done
// - complete flag when shifter done, buffer empty
// - unused high bits ignored, ninth bit written with the byte
// - tx disable waits until everything sent
// - receive to first stop, then store frame
// - unused received high bits read zero
// - error flags travel with their frame
// - received parity checked against data parity
// - rx disable flushes buffer and frame
// - sync mode owns clock pin, direction by role
// - two receive entries, one transmit entry
`timescale 1ns/10ps
module usa_core #(
    parameter int BAUD_W = usa_pkg::BAUD_W
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire usa_pkg::usa_cfg_t cfg_i,
    input wire logic [BAUD_W-1:0] baud_period_i,
    input wire logic tx_enable_i,
    input wire logic rx_enable_i,
    input wire logic tx_write_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_ninth_bit_i,
    input wire logic tx_complete_clear_i,
    input wire logic rx_read_i,
    input wire logic rxd_i,
    input wire logic xfer_clock_pin_i,
    output logic tx_buffer_empty_flag_o,
    output logic tx_complete_flag_o,
    output logic rx_complete_flag_o,
    output logic [7:0] rx_data_o,
    output logic rx_ninth_bit_o,
    output logic frame_error_flag_o,
    output logic overrun_flag_o,
    output logic parity_error_flag_o,
    output logic txd_o,
    output logic txd_oe_n_o,
    output logic xfer_clock_pin_o,
    output logic xfer_clock_pin_oe_n_o
);
    // Synchronisers; stage m is read only by stage s
    logic rxd_m_r, rxd_s_r, rxd_d_r, xck_m_r, xck_s_r, xck_d_r;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            rxd_d_r <= 1'b1;
            xck_m_r <= 1'b0;
            xck_s_r <= 1'b0;
            xck_d_r <= 1'b0;
        end else begin
            rxd_m_r <= rxd_i;
            rxd_s_r <= rxd_m_r;
            rxd_d_r <= rxd_s_r;
            xck_m_r <= xfer_clock_pin_i;
            xck_s_r <= xck_m_r;
            xck_d_r <= xck_s_r;
        end
    end

    // Mode decode
    logic spi, master, slave, async_m, cpha, par_en, odd;
    logic [3:0] dbits; // Effective character length
    assign spi = cfg_i.mode == usa_pkg::MODE_SPI;
    assign master = spi | (cfg_i.mode == usa_pkg::MODE_SYNC_MASTER);
    assign slave = cfg_i.mode == usa_pkg::MODE_SYNC_SLAVE;
    assign async_m = cfg_i.mode == usa_pkg::MODE_ASYNC;
    // Sync modes behave as phase one: change on leading edge
    assign cpha = spi ? cfg_i.spi_clock_phase : !async_m;
    assign dbits = spi ? usa_pkg::DBITS_SPI : cfg_i.data_bits;
    assign par_en = !spi && cfg_i.parity[1];
    assign odd = cfg_i.parity == usa_pkg::PAR_ODD;

    // Builds the bit vector of one frame, bit 0 goes out first
    function automatic logic [12:0] usa_frame(input logic [8:0] d, input logic s,
        input logic lsb, input logic [3:0] n, input logic pe, input logic od);
        logic [12:0] v;
        v = '1; // Stops and filler are high
        if (s) begin
            for (int i = 0; i < 8; i++) begin
                v[i] = lsb ? d[i] : d[7-i];
            end
        end else begin
            v[0] = 1'b0; // Start bit
            for (int i = 0; i < 9; i++) begin
                if (i < n) begin
                    v[i+1] = d[i];
                end
            end
            if (pe) begin
                v[n+1] = ^d ^ od;
            end
        end
        return v;
    endfunction

    // Baud divider, free running; first half bit may be one tick short
    logic [BAUD_W-1:0] bcnt_r, bcnt_nxt;
    logic tick;
    always_comb begin
        tick = bcnt_r == baud_period_i;
        bcnt_nxt = tick ? '0 : bcnt_r + 1'b1;
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bcnt_r <= usa_pkg::BAUD_RST;
        end else begin
            bcnt_r <= bcnt_nxt;
        end
    end

    // Transmit state
    usa_pkg::usa_tx_state_t tst_r, tst_nxt;
    logic [12:0] tsr_r, tsr_nxt, frame;  // Remaining frame bits
    logic [3:0] tlen_r, tlen_nxt, tcnt_r, tcnt_nxt, tos_r, tos_nxt;
    logic [8:0] tbuf_r, tbuf_nxt, cmask;   // Single write buffer
    logic xck_r, xck_nxt, txd_r, txd_nxt, tbuf_empty_r, tbuf_empty_nxt;
    logic txc_r, txc_nxt, tx_on_r, tx_on_nxt;
    logic xs, xd, lead, trail, tx_busy, tx_last, tx_load;
    assign xs = xck_s_r ^ cfg_i.pin_invert;
    assign xd = xck_d_r ^ cfg_i.pin_invert;
    assign tx_busy = tst_r == usa_pkg::TX_SHIFT;
    // Master edges come from the divider only; slave edges from the pin
    assign lead = master ? (tx_busy & tick & ~tos_r[0]) : (slave & xs & ~xd);
    assign trail = master ? (tx_busy & tick & tos_r[0]) :
                   slave ? (~xs & xd) : (tx_busy & tick & (tos_r == usa_pkg::OS_LAST));
    assign cmask = 9'((10'h1 << dbits) - 10'h1);

    always_comb begin
        tst_nxt = tst_r;
        tsr_nxt = tsr_r;
        tlen_nxt = tlen_r;
        tcnt_nxt = tcnt_r;
        tos_nxt = tos_r;
        xck_nxt = xck_r;
        txd_nxt = txd_r;
        tbuf_nxt = tbuf_r;
        tbuf_empty_nxt = tbuf_empty_r;
        txc_nxt = txc_r;
        frame = usa_frame(tbuf_r, spi, cfg_i.spi_lsb_first, dbits, par_en, odd);
        tx_last = tx_busy && trail && (tcnt_r == tlen_r - 4'h1);
        // Pending data still goes out after a disable
        tx_load = !tbuf_empty_r && tx_on_r && (!tx_busy || tx_last);
        if (tx_busy) begin
            if (tick) begin
                tos_nxt = master ? {3'h0, ~tos_r[0]} : tos_r + 4'h1;
            end
            if (lead) begin
                xck_nxt = master;
                if (cpha) begin
                    txd_nxt = tsr_r[0];
                    tsr_nxt = {1'b1, tsr_r[12:1]};
                end
            end
            if (trail) begin
                xck_nxt = 1'b0;
                tcnt_nxt = tcnt_r + 4'h1;
                if (!cpha) begin
                    txd_nxt = tsr_r[0];
                    tsr_nxt = {1'b1, tsr_r[12:1]};
                end
                if (tx_last) begin
                    tst_nxt = usa_pkg::TX_IDLE;
                    txd_nxt = 1'b1; // Line idles high
                end
            end
        end
        if (tx_load) begin
            tst_nxt = usa_pkg::TX_SHIFT;
            tsr_nxt = cpha ? frame : {1'b1, frame[12:1]};
            tlen_nxt = spi ? usa_pkg::DBITS_SPI :
                       dbits + 4'h2 + {3'h0, par_en} + {3'h0, cfg_i.two_stop};
            tcnt_nxt = 4'h0;
            tos_nxt = 4'h0;
            xck_nxt = 1'b0;
            tbuf_empty_nxt = 1'b1;
            if (!cpha) begin
                txd_nxt = frame[0]; // Set up ahead of the first edge
            end
        end
        // Writes while full are dropped; upper bits masked
        if (tx_write_i && tbuf_empty_r && tx_enable_i) begin
            tbuf_nxt = {tx_ninth_bit_i, tx_data_i} & cmask;
            tbuf_empty_nxt = 1'b0;
        end
        if (tx_complete_clear_i) begin
            txc_nxt = 1'b0;
        end
        // A write landing in the last cycle counts as new data
        if (tx_last && !tx_load && tbuf_empty_nxt) begin
            txc_nxt = 1'b1; // Set wins over clear
        end
        // Release waits for an empty shifter and buffer
        tx_on_nxt = tx_enable_i | (tx_on_r & ~(!tx_busy && tbuf_empty_r));
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tst_r <= usa_pkg::TX_IDLE;
            tsr_r <= '1;
            tlen_r <= 4'h0;
            tcnt_r <= 4'h0;
            tos_r <= 4'h0;
            xck_r <= 1'b0;
            txd_r <= 1'b1;
            tbuf_r <= 9'h0;
            tbuf_empty_r <= 1'b1;
            txc_r <= 1'b0;
            tx_on_r <= 1'b0;
        end else begin
            tst_r <= tst_nxt;
            tsr_r <= tsr_nxt;
            tlen_r <= tlen_nxt;
            tcnt_r <= tcnt_nxt;
            tos_r <= tos_nxt;
            xck_r <= xck_nxt;
            txd_r <= txd_nxt;
            tbuf_r <= tbuf_nxt;
            tbuf_empty_r <= tbuf_empty_nxt;
            txc_r <= txc_nxt;
            tx_on_r <= tx_on_nxt;
        end
    end

    // Receive state and two-entry buffer
    usa_pkg::usa_rx_state_t rst_r, rst_nxt;
    logic [3:0] rcnt_r, rcnt_nxt, ros_r, ros_nxt;
    logic [8:0] rdat_r, rdat_nxt;
    logic rpar_r, rpar_nxt, rsmp, rx_done;
    logic [3:0] rfc_r, rfc_nxt; // Entries held
    usa_pkg::usa_rx_entry_t rf0_r, rf0_nxt, rf1_r, rf1_nxt, ent;

    always_comb begin
        rst_nxt = rst_r;
        rcnt_nxt = rcnt_r;
        ros_nxt = ros_r;
        rdat_nxt = rdat_r;
        rpar_nxt = rpar_r;
        rf0_nxt = rf0_r;
        rf1_nxt = rf1_r;
        rfc_nxt = rfc_r;
        rx_done = 1'b0;
        // Sample on the edge opposite to the change edge
        rsmp = async_m ? (rst_r == usa_pkg::RX_RECV && tick && ros_r == usa_pkg::OS_MID) :
               cpha ? trail : lead;
        if (rst_r == usa_pkg::RX_RECV && tick) begin
            ros_nxt = ros_r + 4'h1;
        end
        case (rst_r)
            usa_pkg::RX_IDLE: begin
                if (async_m ? (~rxd_s_r & rxd_d_r) : (!spi && rsmp && !rxd_s_r)) begin
                    rst_nxt = usa_pkg::RX_RECV;
                    rcnt_nxt = async_m ? 4'h0 : 4'h1;
                    ros_nxt = 4'h0;
                    rdat_nxt = 9'h0; // Unused high bits stay zero
                end
            end
            usa_pkg::RX_RECV: begin
                if (rsmp) begin
                    rcnt_nxt = rcnt_r + 4'h1;
                    if (spi) begin
                        rdat_nxt[cfg_i.spi_lsb_first ? rcnt_r[2:0] : 3'h7 - rcnt_r[2:0]] = rxd_s_r;
                        if (rcnt_r == usa_pkg::DBITS_SPI - 4'h1) begin
                            rx_done = 1'b1;
                            rst_nxt = usa_pkg::RX_IDLE;
                        end
                    end else if (rcnt_r == 4'h0) begin
                        if (rxd_s_r) begin
                            rst_nxt = usa_pkg::RX_IDLE; // Start rejected as a spike
                        end
                    end else if (rcnt_r <= dbits) begin
                        rdat_nxt[rcnt_r - 4'h1] = rxd_s_r;
                    end else if (par_en && rcnt_r == dbits + 4'h1) begin
                        rpar_nxt = rxd_s_r;
                    end else begin
                        rx_done = 1'b1; // First stop; a second is ignored
                        rst_nxt = usa_pkg::RX_IDLE;
                    end
                end
            end
            default: begin
                rst_nxt = usa_pkg::RX_IDLE;
            end
        endcase
        ent.data = rdat_nxt[7:0];
        ent.rx_ninth_bit = rdat_nxt[8];
        ent.parity_error_flag = par_en & (rpar_r ^ (^rdat_r) ^ odd);
        ent.frame_error_flag = !spi & !rxd_s_r;
        ent.overrun_flag = 1'b0;
        // SPI reception is framed by the transmitter
        if (spi && tx_load) begin
            rst_nxt = usa_pkg::RX_RECV;
            rcnt_nxt = 4'h0;
            rdat_nxt = 9'h0;
        end
        if (rx_read_i && rfc_r != 4'h0) begin
            rf0_nxt = rf1_r;
            rfc_nxt = rfc_r - 4'h1;
        end
        // Status is stored next to its frame
        if (rx_done) begin
            if (rfc_nxt == usa_pkg::FIFO_FULL) begin
                rf1_nxt.overrun_flag = 1'b1; // New frame lost
            end else if (rfc_nxt == 4'h0) begin
                rf0_nxt = ent;
                rfc_nxt = 4'h1;
            end else begin
                rf1_nxt = ent;
                rfc_nxt = usa_pkg::FIFO_FULL;
            end
        end
        if (!rx_enable_i) begin
            rst_nxt = usa_pkg::RX_IDLE; // Immediate flush
            rfc_nxt = 4'h0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rst_r <= usa_pkg::RX_IDLE;
            rcnt_r <= 4'h0;
            ros_r <= 4'h0;
            rdat_r <= 9'h0;
            rpar_r <= 1'b0;
            rf0_r <= '0;
            rf1_r <= '0;
            rfc_r <= 4'h0;
        end else begin
            rst_r <= rst_nxt;
            rcnt_r <= rcnt_nxt;
            ros_r <= ros_nxt;
            rdat_r <= rdat_nxt;
            rpar_r <= rpar_nxt;
            rf0_r <= rf0_nxt;
            rf1_r <= rf1_nxt;
            rfc_r <= rfc_nxt;
        end
    end

    // Outputs; head entry shown straight from its flops
    assign tx_buffer_empty_flag_o = tbuf_empty_r;
    assign tx_complete_flag_o = txc_r;
    assign rx_complete_flag_o = rfc_r != 4'h0;
    assign rx_data_o = rf0_r.data;
    assign rx_ninth_bit_o = rf0_r.rx_ninth_bit;
    assign frame_error_flag_o = rf0_r.frame_error_flag;
    assign overrun_flag_o = rf0_r.overrun_flag;
    assign parity_error_flag_o = rf0_r.parity_error_flag;
    assign txd_o = txd_r;
    assign txd_oe_n_o = ~tx_on_r;
    assign xfer_clock_pin_o = xck_r ^ cfg_i.pin_invert;
    assign xfer_clock_pin_oe_n_o = ~master;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_sync_change;
        (cfg_i.mode == usa_pkg::MODE_SYNC_MASTER && $changed(txd_r) && $past(tx_busy))
            |-> $past(lead);
    endproperty
    a_sync_change: assert property (p_sync_change) else $error("sync data moved off lead");
    property p_spi_idle;
        (spi && !tx_busy) |-> xfer_clock_pin_o == cfg_i.pin_invert;
    endproperty
    a_spi_idle: assert property (p_spi_idle) else $error("spi clock idle level wrong");
    property p_master_clock;
        (master && $changed(xck_r)) |-> $past(tick) && ($past(tx_busy) || !xck_r);
    endproperty
    a_master_clock: assert property (p_master_clock) else $error("clock off divider");
    property p_frame_len;
        (tx_load && !spi) |=> tlen_r == dbits + 4'h2 + {3'h0, par_en} + {3'h0, cfg_i.two_stop};
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    property p_spi_len;
        (tx_load && spi) |=> tlen_r == 4'h8;
    endproperty
    a_spi_len: assert property (p_spi_len) else $error("spi frame not eight bits");
    property p_load;
        (!tx_busy && !tbuf_empty_r && tx_on_r) |=> tx_busy && tbuf_empty_r;
    endproperty
    a_load: assert property (p_load) else $error("buffer not moved to shifter");
    property p_txc;
        $rose(txc_r) |-> tbuf_empty_r && !tx_busy;
    endproperty
    a_txc: assert property (p_txc) else $error("complete set with data left");
    property p_tx_off;
        $rose(txd_oe_n_o) |-> !$past(tx_busy) && $past(tbuf_empty_r) && !$past(tx_enable_i);
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("pin released early");
    property p_rx_off;
        !rx_enable_i |=> !rx_complete_flag_o && rst_r == usa_pkg::RX_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receiver not flushed");
    property p_overrun;
        (rx_done && rfc_r == 4'h2 && !rx_read_i && rx_enable_i) |=> rf1_r.overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not marked");
    property p_rxc;
        (rx_done && rx_enable_i) |=> rx_complete_flag_o;
    endproperty
    a_rxc: assert property (p_rxc) else $error("frame not stored");
endmodule

// ---- tb/usa_far.sv ----
// Purpose: far-end async serial device that sends frames and captures frames
// Assumes: one bit lasts BIT_CLKS clocks, line idles high
// Notes: captured bits land bit 0 first, bits past len_i stay high
`timescale 1ns/10ps
module usa_far #(
    parameter int BIT_CLKS = 16
) (
    input wire logic mclk_i,
    input wire logic txd_i,
    input wire logic send_i,
    input wire logic [12:0] frame_i,
    input wire logic [3:0] len_i,
    input wire logic sck_i,
    input wire logic cpha_i,
    output logic rxd_o,
    output logic got_o,
    output logic [12:0] got_frame_o,
    output logic [7:0] spi_got_o
);
    int tcnt = 0; // Clocks into the frame being sent
    int rcnt = 0; // Clocks since the captured start edge
    logic [12:0] fr_r = '1; // Frame being sent
    logic busy_r = 1'b0; // Capture in progress
    logic last_r = 1'b1; // Previous line level, for edge finding
    logic sck_q = 1'b0; // Previous SPI clock level, polarity removed
    logic txd_q = 1'b1; // Line as it stood before the edge
    initial begin
        spi_got_o = '0;
        rxd_o = 1'b1;
        got_o = 1'b0;
        got_frame_o = '1;
    end
    // Sender: whole frame, bit 0 first, then back to idle high
    always @(posedge mclk_i) begin
        if (send_i) begin
            fr_r <= frame_i;
            tcnt <= 1;
            rxd_o <= frame_i[0];
        end else if (tcnt > 0 && tcnt < len_i * BIT_CLKS) begin
            rxd_o <= fr_r[tcnt / BIT_CLKS];
            tcnt <= tcnt + 1;
        end else begin
            rxd_o <= 1'b1; // Idle level
            tcnt <= 0;
        end
    end
    // Receiver: find the start edge, sample each bit at its middle
    always @(posedge mclk_i) begin
        got_o <= 1'b0;
        last_r <= txd_i;
        if (!busy_r && last_r && !txd_i) begin
            busy_r <= 1'b1;
            rcnt <= 1;
            got_frame_o <= '1;
        end else if (busy_r) begin
            rcnt <= rcnt + 1;
            if (rcnt % BIT_CLKS == BIT_CLKS / 2) begin
                got_frame_o[rcnt / BIT_CLKS] <= txd_i;
                // Last bit of the agreed length ends the capture
                if (rcnt / BIT_CLKS == len_i - 1) begin
                    busy_r <= 1'b0;
                    got_o <= 1'b1;
                end
            end
        end
    end
    // SPI slave: shift in at the sampling edge, first bit ends highest
    always @(posedge mclk_i) begin
        sck_q <= sck_i;
        txd_q <= txd_i;
        if (sck_i != sck_q && sck_i != cpha_i) begin
            spi_got_o <= {spi_got_o[6:0], txd_q};
        end
    end
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the serial transceiver, async and SPI
// Assumes: baud period 0 in async mode, so one bit is 16 clocks
// Notes: expected frames and receive entries are kept in queues
`timescale 1ns/10ps
module tb;
    localparam int BITC = 16; // Clocks per async bit
    localparam int LIMIT = 60000; // Cycle ceiling, far above the planned run
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    usa_pkg::usa_cfg_t cfg = '0; // Mode 0 is async
    logic tx_en = 1'b0;
    logic rx_en = 1'b0;
    logic wr = 1'b0;
    logic w9 = 1'b0;
    logic tcc = 1'b0;
    logic rd = 1'b0;
    logic snd = 1'b0;
    logic [7:0] wdata = '0;
    logic [12:0] sframe = '1;
    logic [3:0] slen = 4'ha;
    logic empty, done, rxf, r9, fe, ov, pe, txd, txd_oe_n, xfer_clock_pin, xck_oe_n, far_rxd, got;
    logic [7:0] rdat, spi_got;
    logic [11:0] baud = 12'h000; // Divider setting, raised only for SPI
    logic [12:0] gframe;
    wire logic line = txd_oe_n ? 1'b1 : txd; // Pulled up when released
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int n = 8; // Current character length
    int par = 0; // Current parity code
    int two = 0; // Second stop bit
    logic [31:0] seed = 32'hb88c;
    logic [12:0] txq[$]; // Frames the line should carry
    logic [12:0] rxq[$]; // Entries the buffer should return

    usa_core u_usa_core (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_i(cfg), .baud_period_i(baud),
        .tx_enable_i(tx_en), .rx_enable_i(rx_en), .tx_write_i(wr), .tx_data_i(wdata),
        .tx_ninth_bit_i(w9), .tx_complete_clear_i(tcc), .rx_read_i(rd), .rxd_i(far_rxd),
        .xfer_clock_pin_i(1'b0), .tx_buffer_empty_flag_o(empty), .tx_complete_flag_o(done),
        .rx_complete_flag_o(rxf), .rx_data_o(rdat), .rx_ninth_bit_o(r9),
        .frame_error_flag_o(fe), .overrun_flag_o(ov), .parity_error_flag_o(pe),
        .txd_o(txd), .txd_oe_n_o(txd_oe_n), .xfer_clock_pin_o(xfer_clock_pin),
        .xfer_clock_pin_oe_n_o(xck_oe_n));
    usa_far #(.BIT_CLKS(BITC)) u_usa_far (.mclk_i(mclk_i), .txd_i(line), .send_i(snd),
        .frame_i(sframe), .len_i(slen), .sck_i(xfer_clock_pin ^ cfg.pin_invert),
        .cpha_i(cfg.spi_clock_phase), .rxd_o(far_rxd), .got_o(got), .got_frame_o(gframe),
        .spi_got_o(spi_got));

    always #4 mclk_i = ~mclk_i;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [12:0] g, input logic [12:0] e);
        total_checks++;
        if (g !== e) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            fails++;
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected line frame; upper written bits beyond n are dropped
    function automatic logic [12:0] mk(input logic [8:0] d, input logic bp, input logic bs);
        logic [12:0] f;
        logic [8:0] m;
        m = d & 9'((10'h1 << n) - 1);
        f = '1;
        f[0] = 1'b0;
        for (int k = 0; k < n; k++) begin
            f[k + 1] = m[k];
        end
        if (par != 0) begin
            f[n + 1] = ^m ^ (par == 3) ^ bp;
        end
        f[n + 1 + (par != 0)] = ~bs;
        return f;
    endfunction

    // Expected buffer entry: overrun, frame error, parity error, ninth bit, byte
    function automatic logic [12:0] ent(input logic [8:0] d, input logic bp, input logic bs,
        input logic o);
        logic [8:0] m;
        m = d & 9'((10'h1 << n) - 1);
        return {1'b0, o, bs, bp & (par != 0), m};
    endfunction

    // Write only while the buffer is empty, ninth bit in the same strobe
    task automatic wr_byte(input logic [8:0] d);
        for (int w = 0; w < 1000 && empty !== 1'b1; w++) @(negedge mclk_i);
        wdata = d[7:0];
        w9 = d[8];
        wr = 1'b1;
        txq.push_back(mk(d, 1'b0, 1'b0));
        @(negedge mclk_i);
        wr = 1'b0;
    endtask

    task automatic send(input logic [8:0] d, input logic bp, input logic bs, input int wt);
        sframe = mk(d, bp, bs);
        snd = 1'b1;
        @(negedge mclk_i);
        snd = 1'b0;
        repeat (wt) @(negedge mclk_i);
    endtask

    // Status is compared before the pop, as the head advances on a read
    task automatic rd_ent();
        chk({ov, fe, pe, r9, rdat}, rxq.pop_front());
        rd = 1'b1;
        @(negedge mclk_i);
        rd = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask

    // Every frame captured in async mode must match the oldest expected one
    always @(negedge mclk_i) begin
        if (got === 1'b1 && cfg.mode == usa_pkg::MODE_ASYNC) begin
            chk(gframe, (txq.size() > 0) ? txq.pop_front() : 13'h0);
        end
    end

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] r;
        logic [8:0] d;
        int fl;
        repeat (16) @(negedge mclk_i);
        rst_i = 1'b0;
        chk({empty, txd, done, rxf, txd_oe_n}, 13'h19);
        tx_en = 1'b1; // Enables last
        rx_en = 1'b1;
        @(negedge mclk_i);
        chk({txd_oe_n, xck_oe_n}, 13'h1);
        for (int i = 0; i < 10; i++) begin
            // Configuration changes only while both paths are idle
            n = 5 + i % 5;
            par = (i % 3 == 0) ? 0 : 1 + i % 3;
            two = i % 2;
            cfg.data_bits = 4'(n);
            cfg.parity = usa_pkg::usa_par_t'(par[1:0]);
            cfg.two_stop = two[0];
            slen = 4'(2 + n + (par != 0) + two);
            fl = slen * BITC + 32;
            r = rnd();
            wr_byte(r[8:0]);
            r = rnd();
            wr_byte(r[8:0]);
            chk(done, 1'b0);
            for (int w = 0; w < 1000 && done !== 1'b1; w++) @(negedge mclk_i);
            chk(13'(txq.size()), 13'h0);
            tcc = 1'b1;
            @(negedge mclk_i);
            tcc = 1'b0;
            // Three frames into a two-entry buffer, with parity and stop faults
            r = rnd();
            d = r[8:0];
            send(d, 1'b1, 1'b0, fl);
            rxq.push_back(ent(d, 1'b1, 1'b0, 1'b0));
            r = rnd();
            d = r[8:0];
            send(d, 1'b0, 1'b1, fl);
            rxq.push_back(ent(d, 1'b0, 1'b1, 1'b1));
            r = rnd();
            send(r[8:0], 1'b0, 1'b0, fl);
            chk(rxf, 1'b1);
            rd_ent();
            rd_ent();
            chk(rxf, 1'b0);
            // Receiver off with one entry stored and a frame in flight
            send(9'h0, 1'b0, 1'b0, fl);
            send(9'h0, 1'b0, 1'b0, 5 * BITC);
            rx_en = 1'b0;
            repeat (2) @(negedge mclk_i);
            chk(rxf, 1'b0);
            repeat (fl) @(negedge mclk_i);
            rx_en = 1'b1;
            repeat (4) @(negedge mclk_i);
            chk(rxf, 1'b0);
            r = rnd();
            send(r[8:0], 1'b0, 1'b0, fl);
            rxq.push_back(ent(r[8:0], 1'b0, 1'b0, 1'b0));
            rd_ent();
            // Transmitter off right after a write: pin kept until the frame ends
            r = rnd();
            wr_byte(r[8:0]);
            tx_en = 1'b0;
            for (int w = 0; w < 1000 && got !== 1'b1; w++) @(negedge mclk_i);
            chk(txd_oe_n, 1'b0);
            for (int w = 0; w < 1000 && done !== 1'b1; w++) @(negedge mclk_i);
            repeat (2) @(negedge mclk_i);
            chk(txd_oe_n, 1'b1);
            tx_en = 1'b1;
            tcc = 1'b1;
            @(negedge mclk_i);
            tcc = 1'b0;
        end
        // SPI in all four modes; the idle far line comes back as 0xff
        cfg.mode = usa_pkg::MODE_SPI;
        for (int m = 0; m < 4; m++) begin
            r = rnd();
            baud = 12'(m); // Only grows, so the divider never wraps
            cfg.pin_invert = m[1]; // Changed only between transfers
            cfg.spi_clock_phase = m[0];
            cfg.spi_lsb_first = r[8];
            @(negedge mclk_i);
            chk({xck_oe_n, xfer_clock_pin}, 13'(m[1]));
            wr_byte(r[8:0]);
            repeat (80) @(negedge mclk_i);
            for (int k = 0; k < 8; k++) begin
                d[k] = r[8] ? r[7 - k] : r[k];
            end
            chk(spi_got, d[7:0]);
            rxq.push_back(13'h0ff);
            rd_ent();
        end
        give_verdict();
    end
endmodule
